// File: hw/dpl_pkg.sv
package dpl_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_HZ        = 40_000_000;
  localparam int CLR_MIN_NS    = 15;
  localparam int STORE_MS      = 26;
  localparam int LOCK_HOLD_MS  = 100;
  localparam int MS_DIV        = 1000;
  localparam int STORE_CYC     = CLK_HZ / MS_DIV * STORE_MS;
  localparam int LOCK_HOLD_CYC = CLK_HZ / MS_DIV * LOCK_HOLD_MS;

  // ****************************************
  // datapath widths and nominal values
  // ****************************************
  localparam int          ACC_W       = 32;
  localparam int          PH_W        = 16;
  localparam int          CNT_W       = 24;
  localparam int          REG_W       = 16;
  // nominal word puts the oscillator at an eighth of the system clock
  localparam logic [31:0] NOMINAL_FRQ = 32'h2000_0000;

  // ****************************************
  // pin encodings
  // ****************************************
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_HOLD   = 2'h1;
  localparam logic [1:0] MODE_FREE   = 2'h2;
  localparam logic [1:0] MODE_AUTO   = 2'h3;
  localparam logic [1:0] RATE_2K     = 2'h0;
  localparam logic [1:0] RATE_8K     = 2'h1;
  localparam logic [1:0] APP_DS1E1   = 2'h0;
  localparam logic [1:0] APP_DERIVED = 2'h1;
  localparam logic [1:0] APP_SONET   = 2'h3;

  // ****************************************
  // loop filter shifts and slope limits
  // ****************************************
  localparam logic [4:0]  SH_14    = 5'h0C;
  localparam logic [4:0]  SH_29    = 5'h0B;
  localparam logic [4:0]  SH_58    = 5'h0A;
  localparam logic [4:0]  SH_922   = 5'h06;
  localparam logic [15:0] LIM_61U  = 16'h0040;
  localparam logic [15:0] LIM_7U5  = 16'h0008;
  localparam logic [15:0] LIM_9M5  = 16'h2000;

  // ****************************************
  // register map (byte offsets)
  // ****************************************
  localparam logic [5:0]  OFS_CTRL   = 6'h00;
  localparam logic [5:0]  OFS_WINDOW = 6'h04;
  localparam logic [5:0]  OFS_QUAL   = 6'h08;
  localparam logic [5:0]  OFS_STATUS = 6'h0C;
  localparam logic [5:0]  OFS_OFFSET = 6'h10;
  localparam logic [5:0]  OFS_FREQ   = 6'h14;
  localparam logic [15:0] RST_WINDOW = 16'h0200;
  localparam logic [15:0] RST_QUAL   = 16'h0010;

  typedef enum logic [1:0] {ST_FREERUN, ST_NORMAL, ST_HOLDOVER} dpl_state_t;

endpackage

// File: hw/dpl_sync.sv
`timescale 1ns/1ps
module dpl_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb
  begin
    next_meta = d;
    next_q    = meta;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= next_meta;
      q    <= next_q;
    end
  end

endmodule

// File: hw/dpl_core.sv
// Function
// - capture phase offset on switch or return
// - clear low discards offset, realigns to reference
// - realign slowly, along shortest phase path
// - clear held low keeps outputs aligned
// - hitless low keeps old offset on return
// - hitless high recomputes offset on return
// - switching hitless unless clear held low
// - detector error feeds limiter and lock detector
// - slope limit from application and bandwidth
// - 2 kHz fixed 14 Hz, 8 kHz max 58 Hz
// - normal mode locks frequency and phase
// - holdover uses sample 26-52 ms old
// - freerun runs from master clock alone
// - lock after error inside window long enough
// - holdover keeps lock high for 0.1 s
// - freerun drops lock at once
// - state machine driven by mode, select, hitless
// - application select sets out-of-range limits
// - mode encoding 00 normal to 11 auto
// - store frequency every 26 ms, two slots
// - in normal mode, reference failure forces holdover until cleared
// - bandwidth 922 Hz or 29 Hz, slope limits
//
// Chosen here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module dpl_core #(
  parameter int STORE_CYC     = dpl_pkg::STORE_CYC,
  parameter int LOCK_HOLD_CYC = dpl_pkg::LOCK_HOLD_CYC
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // references and monitors
  input  wire logic [2:0]  ref_clk_in,
  input  wire logic [2:0]  ref_fail_in,
  input  wire logic [1:0]  ref_rate_in,
  // controller pins
  input  wire logic        phase_offset_clear_n,
  input  wire logic        hitless_return_enable,
  input  wire logic [1:0]  operating_mode_select,
  input  wire logic [1:0]  reference_select,
  input  wire logic [1:0]  application_select,
  input  wire logic        loop_bandwidth_select,
  // oscillator outputs
  output logic             dco_clk_out,
  output logic             lock_indicator,
  output logic [1:0]       oor_limit_select,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);

  localparam int AW = dpl_pkg::ACC_W;
  localparam int PW = dpl_pkg::PH_W;
  localparam int CW = dpl_pkg::CNT_W;
  localparam int RW = dpl_pkg::REG_W;
  localparam logic [CW-1:0] STORE_END = CW'(STORE_CYC - 1);
  localparam logic [CW-1:0] HOLD_END  = CW'(LOCK_HOLD_CYC - 1);

  // ****************************************
  // input synchronisers
  // ****************************************
  logic        clr_catch;
  logic [16:0] sync_d;
  logic [16:0] sync_q;
  logic [2:0]  ref_s;
  logic [2:0]  fail_s;
  logic [1:0]  rate_s;
  logic [1:0]  refsel_s;
  logic [1:0]  mode_s;
  logic [1:0]  app_s;
  logic        bw_s;
  logic        hitless_s;
  logic        clear_s;

  // a 15 ns low pulse can fall between edges: catch it first
  always_ff @(posedge clk_sys or posedge reset or negedge phase_offset_clear_n)
  begin
    if (reset)
      clr_catch <= 1'b0;
    else if (!phase_offset_clear_n)
      clr_catch <= 1'b1;
    else
      clr_catch <= 1'b0;
  end

  assign sync_d = {ref_clk_in, ref_fail_in, ref_rate_in, reference_select,
                   operating_mode_select, application_select,
                   loop_bandwidth_select, hitless_return_enable, clr_catch};

  dpl_sync #(
    .W (17)
  ) u_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .d       (sync_d),
    .q       (sync_q)
  );

  assign {ref_s, fail_s, rate_s, refsel_s, mode_s, app_s, bw_s, hitless_s, clear_s} = sync_q;

  // ****************************************
  // register file state
  // ****************************************
  logic          soft_clear;
  logic [RW-1:0] lock_window;
  logic [RW-1:0] lock_qual;
  logic          ack;
  logic [31:0]   next_readdata;
  logic          next_soft_clear;
  logic [RW-1:0] next_lock_window;
  logic [RW-1:0] next_lock_qual;
  logic          next_ack;
  logic          clear_act;

  // ****************************************
  // control state
  // ****************************************
  localparam dpl_pkg::dpl_state_t ST_FREERUN  = dpl_pkg::ST_FREERUN;
  localparam dpl_pkg::dpl_state_t ST_NORMAL   = dpl_pkg::ST_NORMAL;
  localparam dpl_pkg::dpl_state_t ST_HOLDOVER = dpl_pkg::ST_HOLDOVER;
  dpl_pkg::dpl_state_t state;
  dpl_pkg::dpl_state_t next_state;
  logic [1:0]    active_ref;
  logic [1:0]    next_active_ref;
  logic          ref_q;
  logic          ref_edge;
  logic          cap_pend;
  logic          next_cap_pend;
  logic          act_fail;

  assign clear_act = clear_s | soft_clear;
  assign act_fail  = fail_s[active_ref];
  assign ref_edge  = ref_s[active_ref] & ~ref_q;

  assign oor_limit_select = app_s;

  // one state machine steers offset and loop
  always_comb
  begin
    next_state      = state;
    next_active_ref = refsel_s;
    case (mode_s)
      dpl_pkg::MODE_FREE:
        next_state = ST_FREERUN;
      dpl_pkg::MODE_HOLD:
        next_state = ST_HOLDOVER;
      default:
        next_state = act_fail ? ST_HOLDOVER : ST_NORMAL;
    endcase
    if (mode_s == dpl_pkg::MODE_AUTO)
    begin
      next_active_ref = active_ref;
      if (active_ref[1] || (act_fail && !fail_s[~active_ref[0]]))
        next_active_ref = {1'b0, ~active_ref[0]};
    end
  end

  // flag a capture on switch or return
  always_comb
  begin
    next_cap_pend = cap_pend;
    if (cap_pend && ref_edge && state == ST_NORMAL)
      next_cap_pend = 1'b0;
    if (next_active_ref != active_ref)
      next_cap_pend = 1'b1;
    else if (state != ST_NORMAL && next_state == ST_NORMAL && hitless_s)
      next_cap_pend = 1'b1;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state      <= ST_FREERUN;
      active_ref <= 2'h0;
      ref_q      <= 1'b0;
      cap_pend   <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      active_ref <= next_active_ref;
      ref_q      <= ref_s[next_active_ref];
      cap_pend   <= next_cap_pend;
    end
  end

  // ****************************************
  // phase detector, limiter, loop filter
  // ****************************************
  logic [AW-1:0]        acc;
  logic [AW-1:0]        freq;
  logic [PW-1:0]        offset;
  logic [AW-1:0]        next_acc;
  logic [AW-1:0]        next_freq;
  logic [PW-1:0]        next_offset;
  logic signed [PW-1:0] phase;
  logic signed [PW-1:0] err;
  logic signed [PW-1:0] err_lim;
  logic signed [PW-1:0] lim;
  logic signed [AW-1:0] err_ext;
  logic [4:0]           shift;
  logic [AW-1:0]        slot0;
  logic [AW-1:0]        slot1;
  logic [AW-1:0]        next_slot0;
  logic [AW-1:0]        next_slot1;
  logic                 wr_sel;
  logic                 next_wr_sel;
  logic [1:0]           slot_fill;
  logic [1:0]           next_slot_fill;
  logic [CW-1:0]        store_cnt;
  logic [CW-1:0]        next_store_cnt;
  logic                 store_tick;

  assign phase = acc[AW-1 -: PW];

  assign err = phase - offset;

  always_comb
  begin
    if (bw_s || app_s == dpl_pkg::APP_DERIVED)
      lim = dpl_pkg::LIM_9M5;
    else if (app_s == dpl_pkg::APP_SONET)
      lim = dpl_pkg::LIM_7U5;
    else
      lim = dpl_pkg::LIM_61U;
    if (err > lim)
      err_lim = lim;
    else if (err < -lim)
      err_lim = -lim;
    else
      err_lim = err;
    if (rate_s == dpl_pkg::RATE_2K)
      shift = dpl_pkg::SH_14;
    else if (rate_s == dpl_pkg::RATE_8K)
      shift = bw_s ? dpl_pkg::SH_58 : dpl_pkg::SH_29;
    else
      shift = bw_s ? dpl_pkg::SH_922 : dpl_pkg::SH_29;
    // error is in phase units: line it up with the accumulator's top bits
    err_ext = {err_lim, {(AW-PW){1'b0}}};
  end

  assign store_tick = (store_cnt == STORE_END);

  always_comb
  begin
    next_offset    = offset;
    next_freq      = freq;
    next_acc       = acc + freq;
    next_slot0     = slot0;
    next_slot1     = slot1;
    next_wr_sel    = wr_sel;
    next_slot_fill = slot_fill;
    next_store_cnt = '0;
    // so a switch then is not hitless
    if (clear_act)
      next_offset = '0;
    // no capture pending means old offset kept
    else if (cap_pend && ref_edge && state == ST_NORMAL)
      next_offset = phase;
    case (state)
      ST_NORMAL:
      begin
        if (ref_edge && !cap_pend)
        begin
          next_freq = freq - AW'(err_ext >>> shift);
          next_acc  = acc + freq - AW'(err_ext >>> 1);
        end
        if (lock_indicator)
        begin
          next_store_cnt = store_tick ? '0 : store_cnt + 1'b1;
          if (store_tick)
          begin
            next_wr_sel = ~wr_sel;
            next_slot_fill = {slot_fill[0], 1'b1};
            if (wr_sel)
              next_slot1 = freq;
            else
              next_slot0 = freq;
          end
        end
      end
      ST_HOLDOVER:
        if (next_state == ST_HOLDOVER && state != next_state)
          next_freq = slot_fill[1] ? (wr_sel ? slot1 : slot0) : freq;
        else
          next_freq = freq;
      default:
        next_freq = dpl_pkg::NOMINAL_FRQ;
    endcase
    if (next_state == ST_HOLDOVER && state == ST_NORMAL)
      next_freq = slot_fill[1] ? (wr_sel ? slot1 : slot0) : freq;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      acc       <= '0;
      freq      <= dpl_pkg::NOMINAL_FRQ;
      offset    <= '0;
      slot0     <= dpl_pkg::NOMINAL_FRQ;
      slot1     <= dpl_pkg::NOMINAL_FRQ;
      wr_sel    <= 1'b0;
      slot_fill <= 2'h0;
      store_cnt <= '0;
    end
    else
    begin
      acc       <= next_acc;
      freq      <= next_freq;
      offset    <= next_offset;
      slot0     <= next_slot0;
      slot1     <= next_slot1;
      wr_sel    <= next_wr_sel;
      slot_fill <= next_slot_fill;
      store_cnt <= next_store_cnt;
    end
  end

  // ****************************************
  // lock detector
  // ****************************************
  logic [RW-1:0] in_win;
  logic [RW-1:0] next_in_win;
  logic [CW-1:0] hold_cnt;
  logic [CW-1:0] next_hold_cnt;
  logic          next_lock;
  logic [PW-1:0] err_abs;

  assign err_abs = err[PW-1] ? PW'(-err) : PW'(err);

  always_comb
  begin
    next_in_win   = in_win;
    next_hold_cnt = '0;
    next_lock     = lock_indicator;
    // qualify over successive edges in window
    if (ref_edge && state == ST_NORMAL)
      next_in_win = (err_abs <= lock_window) ? ((in_win == '1) ? in_win : in_win + 1'b1) : '0;
    case (next_state)
      ST_NORMAL:
        next_lock = (in_win >= lock_qual);
      ST_HOLDOVER:
      begin
        // hold lock 0.1 s into holdover
        next_in_win   = '0;
        next_hold_cnt = (state != ST_HOLDOVER) ? '0 : (hold_cnt == HOLD_END) ? hold_cnt : hold_cnt + 1'b1;
        if (state == ST_HOLDOVER && hold_cnt == HOLD_END)
          next_lock = 1'b0;
      end
      default:
      begin
        next_in_win = '0;
        next_lock   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      in_win         <= '0;
      hold_cnt       <= '0;
      lock_indicator <= 1'b0;
      dco_clk_out    <= 1'b0;
    end
    else
    begin
      in_win         <= next_in_win;
      hold_cnt       <= next_hold_cnt;
      lock_indicator <= next_lock;
      dco_clk_out    <= next_acc[AW-1];
    end
  end

  // ****************************************
  // avalon-mm slave, one wait state
  // ****************************************
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;

  always_comb
  begin
    next_ack         = (avs_read | avs_write) & ~ack;
    next_soft_clear  = soft_clear;
    next_lock_window = lock_window;
    next_lock_qual   = lock_qual;
    next_readdata    = avs_readdata;
    if (avs_write && ack)
    begin
      if (avs_address == dpl_pkg::OFS_CTRL)
        next_soft_clear = avs_writedata[0];
      else if (avs_address == dpl_pkg::OFS_WINDOW)
        next_lock_window = avs_writedata[RW-1:0];
      else if (avs_address == dpl_pkg::OFS_QUAL)
        next_lock_qual = avs_writedata[RW-1:0];
    end
    // data is loaded during the wait cycle so it stands at the answer edge
    if (avs_read && !ack)
    begin
      if (avs_address == dpl_pkg::OFS_CTRL)
        next_readdata = {31'h0, soft_clear};
      else if (avs_address == dpl_pkg::OFS_WINDOW)
        next_readdata = {16'h0, lock_window};
      else if (avs_address == dpl_pkg::OFS_QUAL)
        next_readdata = {16'h0, lock_qual};
      else if (avs_address == dpl_pkg::OFS_STATUS)
        next_readdata = {22'h0, shift, active_ref, state, lock_indicator};
      else if (avs_address == dpl_pkg::OFS_OFFSET)
        next_readdata = {16'h0, offset};
      else if (avs_address == dpl_pkg::OFS_FREQ)
        next_readdata = freq;
      else
        next_readdata = 32'h0;
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      ack          <= 1'b0;
      soft_clear   <= 1'b0;
      lock_window  <= dpl_pkg::RST_WINDOW;
      lock_qual    <= dpl_pkg::RST_QUAL;
      avs_readdata <= 32'h0;
    end
    else
    begin
      ack          <= next_ack;
      soft_clear   <= next_soft_clear;
      lock_window  <= next_lock_window;
      lock_qual    <= next_lock_qual;
      avs_readdata <= next_readdata;
    end
  end

endmodule

// File: testbench/dpl_core_chk.sv
`timescale 1ns/1ps
module dpl_core_chk #(
  parameter int STORE_CYC     = 64,
  parameter int LOCK_HOLD_CYC = 200
) (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        reset,
  // references
  input wire logic [2:0]  ref_clk_in,
  input wire logic [2:0]  ref_fail_in,
  input wire logic [1:0]  ref_rate_in,
  // controller pins
  input wire logic        phase_offset_clear_n,
  input wire logic        hitless_return_enable,
  input wire logic [1:0]  operating_mode_select,
  input wire logic [1:0]  reference_select,
  input wire logic [1:0]  application_select,
  input wire logic        loop_bandwidth_select,
  // oscillator outputs
  input wire logic        dco_clk_out,
  input wire logic        lock_indicator,
  input wire logic [1:0]  oor_limit_select,
  // register bus
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest
);
  // *****
  // cycles since reset, saturating
  // *****
  // pin synchronisers hide the first edges, so rules wait on this
  localparam int HOLD_LATE = LOCK_HOLD_CYC + 30;
  logic [7:0] run_cnt;
  logic [7:0] next_run_cnt;
  always_comb next_run_cnt = (run_cnt == 8'hFF) ? run_cnt : run_cnt + 8'h01;
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
      run_cnt <= 8'h00;
    else
      run_cnt <= next_run_cnt;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence hold_entry;
    run_cnt > 8'h04 && lock_indicator && operating_mode_select == dpl_pkg::MODE_HOLD &&
      $past(operating_mode_select) == dpl_pkg::MODE_NORMAL;
  endsequence

  // *****
  // assertions
  // *****
  AST_OOR_ECHO: assert property ((run_cnt > 8'h04 && $stable(application_select)) [*3]
    |-> oor_limit_select == application_select) else $error("oor limit differs from select");
  AST_FREE_UNLOCK: assert property ((run_cnt > 8'h04 && operating_mode_select == dpl_pkg::MODE_FREE) [*5]
    |-> !lock_indicator) else $error("lock high in freerun");
  AST_FREE_RUNS: assert property ((run_cnt > 8'h04 && operating_mode_select == dpl_pkg::MODE_FREE) [*8]
    |-> ##[1:12] $changed(dco_clk_out)) else $error("oscillator stalled in freerun");
  AST_HOLD_KEEP: assert property (hold_entry |-> lock_indicator [*8])
    else $error("lock dropped early in holdover");
  AST_HOLD_DROP: assert property (hold_entry |-> ##HOLD_LATE
    (!lock_indicator || operating_mode_select != dpl_pkg::MODE_HOLD)) else $error("lock stuck in holdover");
  AST_FAIL_KEEP: assert property (run_cnt > 8'h04 && $rose(ref_fail_in[0]) && reference_select == 2'h0 &&
    operating_mode_select == dpl_pkg::MODE_NORMAL && lock_indicator |-> lock_indicator [*8])
    else $error("lock dropped at reference failure");
  AST_LOCK_LATE: assert property ($rose(lock_indicator) |-> run_cnt > 8'h64)
    else $error("lock before qualify time");
  AST_BUS_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");
  AST_BUS_IDLE: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest without request");

  COV_LOCK: cover property ($rose(lock_indicator));
  COV_HOLD: cover property (hold_entry);
  COV_FREE: cover property ($fell(lock_indicator) && operating_mode_select == dpl_pkg::MODE_FREE);
endmodule

bind dpl_core dpl_core_chk #(.STORE_CYC(STORE_CYC), .LOCK_HOLD_CYC(LOCK_HOLD_CYC)) u_chk (
  .clk_sys(clk_sys), .reset(reset), .ref_clk_in(ref_clk_in), .ref_fail_in(ref_fail_in),
  .ref_rate_in(ref_rate_in), .phase_offset_clear_n(phase_offset_clear_n),
  .hitless_return_enable(hitless_return_enable), .operating_mode_select(operating_mode_select),
  .reference_select(reference_select), .application_select(application_select),
  .loop_bandwidth_select(loop_bandwidth_select), .dco_clk_out(dco_clk_out),
  .lock_indicator(lock_indicator), .oor_limit_select(oor_limit_select), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

// File: testbench/dpl_refs.sv
`timescale 1ns/1ps
module dpl_refs (
  // bench controls
  input  wire logic [2:0] fail_req,
  input  wire logic [1:0] rate_req,
  // reference side
  output logic      [2:0] ref_clk,
  output logic      [2:0] ref_fail,
  output logic      [1:0] ref_rate
);
  // *****
  // free-running references, 200 ns, phases apart
  // *****
  localparam int PH [3] = '{7, 57, 147};
  for (genvar i = 0; i < 3; i++)
  begin : g_ref
    initial
    begin
      ref_clk[i] = 1'b0;
      #(PH[i]);
      forever #100 ref_clk[i] = ~ref_clk[i];
    end
  end
  assign ref_fail = fail_req;
  assign ref_rate = rate_req;
endmodule

// File: testbench/tb_dpl_core.sv
`timescale 1ns/1ps
module tb_dpl_core;
  // *****
  // signals
  // *****
  typedef struct packed {
    logic [1:0] app;
    logic       bw;
    logic [1:0] rate;
    logic [4:0] sh;
  } dpl_row_t;
  localparam int         LOCK_HOLD  = 200;
  localparam logic [1:0] ST_EXP [4] = '{2'h1, 2'h2, 2'h0, 2'h1};
  logic        clk_sys, reset, clr_n, hitless, bw, digitally_controlled_oscillator, lock, dprev;
  logic [1:0]  mode, rsel, app, rate_req, oor, ref_rate;
  logic [2:0]  ref_clk, ref_fail, fail_req;
  logic [5:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, q, off_a;
  int          bad_count, n_tests, cyc, n, t, e;
  dpl_row_t    rows [6];

  dpl_refs u_refs (.fail_req(fail_req), .rate_req(rate_req), .ref_clk(ref_clk), .ref_fail(ref_fail),
    .ref_rate(ref_rate));
  dpl_core #(.STORE_CYC(64), .LOCK_HOLD_CYC(LOCK_HOLD)) u_dut (
    .clk_sys(clk_sys), .reset(reset), .ref_clk_in(ref_clk), .ref_fail_in(ref_fail), .ref_rate_in(ref_rate),
    .phase_offset_clear_n(clr_n), .hitless_return_enable(hitless), .operating_mode_select(mode),
    .reference_select(rsel), .application_select(app), .loop_bandwidth_select(bw), .dco_clk_out(digitally_controlled_oscillator),
    .lock_indicator(lock), .oor_limit_select(oor), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  // *****
  // clock, watchdog, tasks
  // *****
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      conclude();
    end
  end
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // master holds the request until waitrequest is seen low
  task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    do
      @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task rd(input logic [5:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task waitc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  task wait_lock;
    n = 0;
    while (lock !== 1'b1 && n < 4000)
    begin
      @(negedge clk_sys);
      n++;
    end
    check("lock", {31'h0, lock}, 32'h1);
  endtask
  task state_is(input logic [1:0] s);
    rd(dpl_pkg::OFS_STATUS);
    check("state", {30'h0, q[2:1]}, {30'h0, s});
  endtask

  // *****
  // main sequence
  // *****
  initial
  begin
    bad_count = 0;
    n_tests = 0;
    cyc = 0;
    reset = 1'b1;
    clr_n = 1'b1;
    hitless = 1'b0;
    bw = 1'b1;
    mode = dpl_pkg::MODE_NORMAL;
    rsel = 2'h0;
    app = 2'h0;
    rate_req = 2'h2;
    fail_req = 3'h0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    rows = '{'{2'h0, 1'b0, dpl_pkg::RATE_2K, dpl_pkg::SH_14}, '{2'h1, 1'b1, dpl_pkg::RATE_2K, dpl_pkg::SH_14},
      '{2'h2, 1'b1, dpl_pkg::RATE_8K, dpl_pkg::SH_58}, '{2'h3, 1'b0, dpl_pkg::RATE_8K, dpl_pkg::SH_29},
      '{2'h0, 1'b1, 2'h2, dpl_pkg::SH_922}, '{2'h3, 1'b0, 2'h2, dpl_pkg::SH_29}};
    repeat (3) @(posedge clk_sys);
    check("lock in reset", {31'h0, lock}, 32'h0);
    check("dco in reset", {31'h0, digitally_controlled_oscillator}, 32'h0);
    check("readdata in reset", avs_readdata, 32'h0);
    reset <= 1'b0;
    rd(dpl_pkg::OFS_WINDOW);
    check("window reset", q, {16'h0, dpl_pkg::RST_WINDOW});
    rd(dpl_pkg::OFS_QUAL);
    check("qualify reset", q, {16'h0, dpl_pkg::RST_QUAL});
    bus(1'b1, 6'h3C, 32'hFFFF_FFFF);
    rd(6'h3C);
    check("unmapped", q, 32'h0);
    bus(1'b1, dpl_pkg::OFS_WINDOW, 32'h0000_0300);
    rd(dpl_pkg::OFS_WINDOW);
    check("window rw", q, 32'h0000_0300);
    foreach (rows[i])
    begin
      @(posedge clk_sys);
      app <= rows[i].app;
      bw <= rows[i].bw;
      rate_req <= rows[i].rate;
      waitc(6);
      check("oor_limit_select", {30'h0, oor}, {30'h0, rows[i].app});
      rd(dpl_pkg::OFS_STATUS);
      check("filter shift", {27'h0, q[9:5]}, {27'h0, rows[i].sh});
    end
    @(posedge clk_sys);
    app <= 2'h0;
    bw <= 1'b1;
    rate_req <= 2'h2;
    wait_lock();
    state_is(2'h1);
    @(posedge clk_sys);
    rsel <= 2'h1;
    waitc(40);
    rd(dpl_pkg::OFS_OFFSET);
    check("offset captured", {31'h0, q != 32'h0}, 32'h1);
    @(posedge clk_sys);
    clr_n <= 1'b0;
    @(posedge clk_sys);
    clr_n <= 1'b1;
    waitc(6);
    rd(dpl_pkg::OFS_OFFSET);
    check("offset after clear", q, 32'h0);
    @(posedge clk_sys);
    clr_n <= 1'b0;
    rsel <= 2'h2;
    waitc(40);
    rd(dpl_pkg::OFS_OFFSET);
    check("offset clear held", q, 32'h0);
    @(posedge clk_sys);
    clr_n <= 1'b1;
    waitc(8);
    @(posedge clk_sys);
    rsel <= 2'h0;
    waitc(40);
    wait_lock();
    rd(dpl_pkg::OFS_OFFSET);
    off_a = q;
    check("offset on switch", {31'h0, q != 32'h0}, 32'h1);
    @(posedge clk_sys);
    mode <= dpl_pkg::MODE_HOLD;
    waitc(10);
    check("lock early holdover", {31'h0, lock}, 32'h1);
    waitc(LOCK_HOLD + 20);
    check("lock late holdover", {31'h0, lock}, 32'h0);
    state_is(2'h2);
    @(posedge clk_sys);
    mode <= dpl_pkg::MODE_NORMAL;
    waitc(40);
    rd(dpl_pkg::OFS_OFFSET);
    check("offset kept", q, off_a);
    wait_lock();
    @(posedge clk_sys);
    fail_req <= 3'h1;
    waitc(8);
    check("lock at failure", {31'h0, lock}, 32'h1);
    state_is(2'h2);
    @(posedge clk_sys);
    fail_req <= 3'h0;
    waitc(8);
    state_is(2'h1);
    for (int m = 0; m < 4; m++)
    begin
      @(posedge clk_sys);
      mode <= m[1:0];
      waitc(6);
      rd(dpl_pkg::OFS_STATUS);
      check("mode state", {30'h0, q[2:1]}, {30'h0, ST_EXP[m]});
    end
    wait_lock();
    @(posedge clk_sys);
    mode <= dpl_pkg::MODE_FREE;
    waitc(4);
    check("lock in freerun", {31'h0, lock}, 32'h0);
    t = 0;
    dprev = digitally_controlled_oscillator;
    repeat (200)
    begin
      @(negedge clk_sys);
      if (digitally_controlled_oscillator !== dprev)
        t++;
      dprev = digitally_controlled_oscillator;
    end
    e = int'((longint'(200) * longint'(dpl_pkg::NOMINAL_FRQ)) >> 31);
    check("freerun toggles", {31'h0, t == e || t == e + 1}, 32'h1);
    conclude();
  end
endmodule
